// ===== core/fsc_defs.svh
// constants of the fault status and control register bank
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH

// ****************************************
// register addresses
// ****************************************
`define FSC_ADDR_PRIMARY     3'h0
`define FSC_ADDR_DETAIL      3'h1
`define FSC_ADDR_CTRL        3'h2
`define FSC_ADDR_LAST        3'h5

// ****************************************
// serial frame
// ****************************************
`define FSC_FRAME_BITS       5'h10
`define FSC_HEAD_BITS        5'h04
`define FSC_CNT_MAX          5'h11
`define FSC_ADDR_LAST_BIT    5'h03

// ****************************************
// primary status word bit positions
// ****************************************
`define FSC_P_ERROR          11
`define FSC_P_SUPPLY_UV      10
`define FSC_P_PUMP_LOW       8
`define FSC_P_DS_OC          7
`define FSC_P_SHUNT_OC       6
`define FSC_P_THERM_WARN     5
`define FSC_P_THERM_SD       4
`define FSC_P_CONV_OC        2
`define FSC_P_CONV_UV        1
`define FSC_P_CONV_OV        0

// ****************************************
// detail status word field positions
// ****************************************
`define FSC_D_SHUNT_LSB      9
`define FSC_D_FET_LSB        3

// ****************************************
// control word reset value and lock codes
// ****************************************
`define FSC_CTRL_RESET       12'h3a4
`define FSC_LOCK_CODE        3'h6
`define FSC_UNLOCK_CODE      3'h3

// ****************************************
// dead time in ns and clock rate in MHz
// ****************************************
`define FSC_REF_MHZ          100
`define FSC_DT0_NS           100
`define FSC_DT1_NS           150
`define FSC_DT2_NS           250
`define FSC_DT3_NS           450
`define FSC_NS2CYC(ns, mhz)  (((ns) * (mhz) + 999) / 1000)

`endif

// ===== core/fsc_pkg.sv
// types of the fault status and control register bank
package fsc_pkg;

    // control word layout, bit 11 down to bit 0
    typedef struct packed {
        logic       clear_errors_bit;
        logic [2:0] write_lock;
        logic       pump_protect_select;
        logic       backemf_sample_hold_on;
        logic       thermal_warning_pin_report;
        logic       pwm_mode;
        logic [1:0] dead_time;
        logic       sense_mode;
        logic       sense_sample_hold_on;
    } fsc_ctrl_t;

    // raw detector events; shunt order a,b,c; fet order ah,al,bh,bl,ch,cl
    typedef struct packed {
        logic       supply_undervoltage_flag;
        logic       pump_low_flag;
        logic       thermal_warning_flag;
        logic       thermal_shutdown_flag;
        logic       converter_overcurrent_flag;
        logic       converter_undervoltage_flag;
        logic       converter_overvoltage_flag;
        logic [2:0] shunt_oc;
        logic [5:0] fet_oc;
    } fsc_event_t;

    // configuration handed to the gate drive logic
    typedef struct packed {
        logic       backemf_sample_hold_on;
        logic       sense_sample_hold_on;
        logic       pwm_mode;
        logic       sense_mode;
        logic [5:0] dead_time_cycles;
        logic       pump_protect_trip;
    } fsc_drive_cfg_t;

    // whole state of the reference clock domain
    typedef struct packed {
        logic           cs_meta;
        logic           cs_sync;
        logic           cs_prev;
        logic           en_meta;
        logic           en_sync;
        logic           en_prev;
        fsc_event_t     evt_meta;
        fsc_event_t     evt_sync;
        logic           frame_seen;
        logic [11:0]    primary;
        logic [11:0]    detail;
        fsc_ctrl_t      ctrl;
        logic [11:0]    shadow_p;
        logic [11:0]    shadow_d;
        logic [11:0]    shadow_c;
        logic           error_pin_n;
        fsc_drive_cfg_t drive;
    } fsc_state_t;

endpackage : fsc_pkg

// ===== core/fsc_fault_status_control_regs.sv
// fault status words, first control word and serial slave of the gate driver
`timescale 1ns/100ps
`include "fsc_defs.svh"
module fsc_fault_status_control_regs #(
    parameter int REF_MHZ = `FSC_REF_MHZ
) (
    // reference clock, reset, freeze
    input  wire logic                   ref_clk,
    input  wire logic                   rstn,
    input  wire logic                   clk_en,
    // serial link from the host
    input  wire logic                   link_sclk,
    input  wire logic                   link_cs_n,
    input  wire logic                   link_sdi,
    output logic                        link_sdo,
    // power state, same clock as ref_clk
    input  wire logic                   sleep_active,
    input  wire logic                   shutdown_active,
    // enable pin, asynchronous
    input  wire logic                   enable_pin,
    // analog detectors, asynchronous
    input  wire fsc_pkg::fsc_event_t    fault_events,
    // drive configuration and fault pin
    output fsc_pkg::fsc_drive_cfg_t     drive_cfg,
    output logic                        error_output_pin_n
);

    // ****************************************
    // functions
    // ****************************************

    // address window that the slave answers at all
    function automatic logic fsc_addr_ok(input logic [2:0] addr);
        fsc_addr_ok = (addr <= `FSC_ADDR_LAST);
    endfunction : fsc_addr_ok

    // dead time code to reference clock cycles, rounded up
    function automatic logic [5:0] fsc_dead_cycles(input logic [1:0] code);
        logic [5:0] cyc;
        cyc = 6'(`FSC_NS2CYC(`FSC_DT1_NS, REF_MHZ));
        unique case (code)
            2'h0: cyc = 6'(`FSC_NS2CYC(`FSC_DT0_NS, REF_MHZ));
            2'h1: cyc = 6'(`FSC_NS2CYC(`FSC_DT1_NS, REF_MHZ));
            2'h2: cyc = 6'(`FSC_NS2CYC(`FSC_DT2_NS, REF_MHZ));
            2'h3: cyc = 6'(`FSC_NS2CYC(`FSC_DT3_NS, REF_MHZ));
        endcase
        fsc_dead_cycles = cyc;
    endfunction : fsc_dead_cycles

    // ****************************************
    // link clock domain
    // ****************************************

    // link state; a separate set because two edges of a foreign clock drive it
    logic        fresh_ff;
    logic [15:0] shift_ff;
    logic [4:0]  cnt_ff;
    logic [2:0]  addr_ff;
    logic        frame_tgl_ff;
    logic        sdo_ff;
    logic        link_clr_n;
    logic [11:0] rd_word;
    logic [3:0]  rd_idx;

    fsc_pkg::fsc_state_t s_ff;
    fsc_pkg::fsc_state_t nxt_s;

    // deselect ends the frame; the link clock may stop, so the pin clears it
    assign link_clr_n = rstn & ~link_cs_n;

    // marks that the next falling edge is the first of a frame
    always_ff @(negedge link_sclk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            fresh_ff <= 1'b1;
        end else begin
            fresh_ff <= 1'b0;
        end
    end

    // capture on falling edge, msb first; count saturates past 16
    always_ff @(negedge link_sclk or negedge rstn) begin
        if (!rstn) begin
            shift_ff     <= 16'h0000;
            cnt_ff       <= 5'h00;
            addr_ff      <= 3'h0;
            frame_tgl_ff <= 1'b0;
        end else if (fresh_ff) begin
            shift_ff     <= {15'h0000, link_sdi};
            cnt_ff       <= 5'h01;
            frame_tgl_ff <= ~frame_tgl_ff;                             // announces a new frame
        end else begin
            shift_ff <= {shift_ff[14:0], link_sdi};
            if (cnt_ff != `FSC_CNT_MAX) begin
                cnt_ff <= cnt_ff + 5'h01;
            end
            if (cnt_ff == `FSC_ADDR_LAST_BIT) begin
                addr_ff <= {shift_ff[1:0], link_sdi};
            end
        end
    end

    // register picked by the frame address; shadows are frozen in a frame
    always_comb begin
        rd_word = 12'h000;
        rd_idx  = 4'(5'h0f - cnt_ff);
        unique case (addr_ff)
            `FSC_ADDR_PRIMARY: rd_word = s_ff.shadow_p;
            `FSC_ADDR_DETAIL:  rd_word = s_ff.shadow_d;
            `FSC_ADDR_CTRL:    rd_word = s_ff.shadow_c;
            default:           rd_word = 12'h000;
        endcase
    end

    // launch on rising edge: low in the head, then data 11 down to 0
    always_ff @(posedge link_sclk or negedge link_clr_n) begin
        if (!link_clr_n) begin
            sdo_ff <= 1'b0;
        end else if (!fresh_ff && cnt_ff >= `FSC_HEAD_BITS && cnt_ff < `FSC_FRAME_BITS
                     && fsc_addr_ok(addr_ff)) begin
            sdo_ff <= rd_word[rd_idx];
        end else begin
            sdo_ff <= 1'b0;
        end
    end

    assign link_sdo = sdo_ff;

    // ****************************************
    // reference clock domain
    // ****************************************

    // frame decode and flag update
    always_comb begin
        logic              frame_end;
        logic              frame_ok;
        logic              clr;
        logic              locked;
        logic              any_set;
        logic              warn_pin;
        logic [2:0]        waddr;
        fsc_pkg::fsc_ctrl_t    wdata;
        fsc_pkg::fsc_event_t   ev;
        logic [11:0]       set_p;
        logic [11:0]       set_d;

        nxt_s     = s_ff;
        frame_end = 1'b0;
        frame_ok  = 1'b0;
        clr       = 1'b0;
        waddr     = shift_ff[14:12];
        wdata     = fsc_pkg::fsc_ctrl_t'(shift_ff[11:0]);
        ev        = s_ff.evt_sync;
        locked    = (s_ff.ctrl.write_lock == `FSC_LOCK_CODE);
        set_p     = 12'h000;
        set_d     = 12'h000;
        any_set   = 1'b0;
        warn_pin  = 1'b0;

        // two-stage synchronisers for pins and detectors
        nxt_s.cs_meta  = link_cs_n;
        nxt_s.cs_sync  = s_ff.cs_meta;
        nxt_s.cs_prev  = s_ff.cs_sync;
        nxt_s.en_meta  = enable_pin;
        nxt_s.en_sync  = s_ff.en_meta;
        nxt_s.en_prev  = s_ff.en_sync;
        nxt_s.evt_meta = fault_events;
        nxt_s.evt_sync = s_ff.evt_meta;

        // frame is taken once deselect is seen; link regs are then still
        frame_end = s_ff.cs_sync & ~s_ff.cs_prev & (frame_tgl_ff != s_ff.frame_seen);
        if (frame_end) begin
            nxt_s.frame_seen = frame_tgl_ff;
        end
        frame_ok = frame_end & (cnt_ff == `FSC_FRAME_BITS) & fsc_addr_ok(waddr);

        // write to the control word; status words take no write
        if (frame_ok && !shift_ff[15] && waddr == `FSC_ADDR_CTRL) begin
            if (!locked) begin
                nxt_s.ctrl                  = wdata;
                nxt_s.ctrl.write_lock       = s_ff.ctrl.write_lock;
                nxt_s.ctrl.clear_errors_bit = 1'b0;
                clr                         = wdata.clear_errors_bit;
            end
            if (wdata.write_lock == `FSC_LOCK_CODE || wdata.write_lock == `FSC_UNLOCK_CODE) begin
                nxt_s.ctrl.write_lock = wdata.write_lock;
            end
        end

        // rising enable after a low pulse is the recovery clear
        if (s_ff.en_sync && !s_ff.en_prev) begin
            clr = 1'b1;
        end

        // power state entry wins over any write of the same cycle
        if (sleep_active || shutdown_active) begin
            nxt_s.ctrl = fsc_pkg::fsc_ctrl_t'(`FSC_CTRL_RESET);
        end

        // events that set latched primary bits
        set_p[`FSC_P_SUPPLY_UV] = ev.supply_undervoltage_flag;
        set_p[`FSC_P_PUMP_LOW]  = ev.pump_low_flag;
        set_p[`FSC_P_DS_OC]     = |ev.fet_oc;
        set_p[`FSC_P_SHUNT_OC]  = |ev.shunt_oc;
        set_p[`FSC_P_THERM_SD]  = ev.thermal_shutdown_flag;
        set_p[`FSC_P_CONV_OC]   = ev.converter_overcurrent_flag;
        set_p[`FSC_P_CONV_UV]   = ev.converter_undervoltage_flag;
        set_p[`FSC_P_CONV_OV]   = ev.converter_overvoltage_flag;
        warn_pin = ev.thermal_warning_flag & s_ff.ctrl.thermal_warning_pin_report;
        any_set  = (|set_p) | warn_pin;
        set_p[`FSC_P_ERROR]     = any_set;

        // detail word: shunt a,b,c then fets ah..cl
        set_d[`FSC_D_SHUNT_LSB +: 3] = ev.shunt_oc;
        set_d[`FSC_D_FET_LSB +: 6]   = ev.fet_oc;

        // set wins over clear so an event in the clear cycle survives
        nxt_s.primary = (s_ff.primary & ~{12{clr}}) | set_p;
        nxt_s.detail  = (s_ff.detail & ~{12{clr}}) | set_d;
        nxt_s.primary[`FSC_P_THERM_WARN] = ev.thermal_warning_flag;
        nxt_s.primary[9]                 = 1'b0;
        nxt_s.primary[3]                 = 1'b0;
        nxt_s.detail[2:0]                = 3'h0;

        // fault pin: any latched fault, or a reported live warning
        nxt_s.error_pin_n = ~(nxt_s.primary[`FSC_P_ERROR] |
                              (ev.thermal_warning_flag & nxt_s.ctrl.thermal_warning_pin_report));

        // configuration to the drive logic
        nxt_s.drive.pump_protect_trip      = nxt_s.primary[`FSC_P_PUMP_LOW] &
                                             nxt_s.ctrl.pump_protect_select;
        nxt_s.drive.backemf_sample_hold_on = nxt_s.ctrl.backemf_sample_hold_on;
        nxt_s.drive.pwm_mode               = nxt_s.ctrl.pwm_mode;
        nxt_s.drive.dead_time_cycles       = fsc_dead_cycles(nxt_s.ctrl.dead_time);
        nxt_s.drive.sense_mode             = nxt_s.ctrl.sense_mode;
        nxt_s.drive.sense_sample_hold_on   = nxt_s.ctrl.sense_sample_hold_on;

        // shadows follow only while deselected, so the link sees still words
        if (s_ff.cs_sync && nxt_s.cs_sync) begin
            nxt_s.shadow_p = nxt_s.primary;
            nxt_s.shadow_d = nxt_s.detail;
            nxt_s.shadow_c = nxt_s.ctrl;
        end
    end

    // state register; clk_en low freezes the whole reference domain
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_ff                              <= '0;
            s_ff.cs_meta                      <= 1'b1;
            s_ff.cs_sync                      <= 1'b1;
            s_ff.cs_prev                      <= 1'b1;
            s_ff.en_meta                      <= 1'b1;                 // enable idles high: no false
            s_ff.en_sync                      <= 1'b1;                 // recovery edge after reset
            s_ff.en_prev                      <= 1'b1;
            s_ff.ctrl                         <= fsc_pkg::fsc_ctrl_t'(`FSC_CTRL_RESET);
            s_ff.shadow_c                     <= `FSC_CTRL_RESET;
            s_ff.error_pin_n                  <= 1'b1;
            s_ff.drive.dead_time_cycles       <= 6'(`FSC_NS2CYC(`FSC_DT1_NS, REF_MHZ));
        end else if (clk_en) begin
            s_ff <= nxt_s;
        end
    end

    assign drive_cfg          = s_ff.drive;
    assign error_output_pin_n = s_ff.error_pin_n;

endmodule : fsc_fault_status_control_regs

// ===== sim/fsc_fault_status_control_regs_chk.sv
// port assertions for the fault status and control register bank
`timescale 1ns/100ps
module fsc_fault_status_control_regs_chk (
    // clock and reset
    input wire logic                    ref_clk,
    input wire logic                    rstn,
    // link and power state
    input wire logic                    link_cs_n,
    input wire logic                    link_sdo,
    input wire logic                    sleep_active,
    input wire logic                    shutdown_active,
    // detectors and outputs
    input wire fsc_pkg::fsc_event_t     fault_events,
    input wire fsc_pkg::fsc_drive_cfg_t drive_cfg,
    input wire logic                    error_output_pin_n
);
    // ****************************************
    // helpers
    // ****************************************
    wire any_evt = |fault_events;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    property p_dt_code;
        drive_cfg.dead_time_cycles inside {6'h0a, 6'h0f, 6'h19, 6'h2d};
    endproperty
    a_dt_code: assert property (p_dt_code) else $error("dead time off table");

    property p_sleep;
        (sleep_active || shutdown_active) [*3] |-> drive_cfg[10:1] == {4'h0, 6'h0f};
    endproperty
    a_sleep: assert property (p_sleep) else $error("config not default in low power");

    // sdo must be quiet once deselected
    property p_sdo_idle;
        link_cs_n && $past(link_cs_n) |-> !link_sdo;
    endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo driven while deselected");

    property p_pin_fall;
        $fell(error_output_pin_n) |-> $past(any_evt, 1) || $past(any_evt, 2) || $past(any_evt, 3);
    endproperty
    a_pin_fall: assert property (p_pin_fall) else $error("fault pin fell without event");

    property p_trip_pin;
        $rose(drive_cfg.pump_protect_trip) |-> ##[0:2] !error_output_pin_n;
    endproperty
    a_trip_pin: assert property (p_trip_pin) else $error("trip without fault pin");

    // config may only move after a finished frame or a power state
    property p_cfg_quiet;
        $changed(drive_cfg[10:1]) |-> (link_cs_n && $past(link_cs_n, 2)) || $past(sleep_active)
            || $past(shutdown_active) || $past(sleep_active, 2) || $past(shutdown_active, 2);
    endproperty
    a_cfg_quiet: assert property (p_cfg_quiet) else $error("config moved mid frame");

    property p_reset_out;
        $rose(rstn) |-> error_output_pin_n && !link_sdo && drive_cfg.dead_time_cycles == 6'h0f;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not at reset value");

    // a latched fault cannot clear while a frame is still open; the check makes no exception for the enable pin recovery clear
    property p_pin_hold;
        !error_output_pin_n && !link_cs_n |=> !error_output_pin_n;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("fault pin released mid frame");

    c_trip: cover property (drive_cfg.pump_protect_trip);
    c_pin: cover property ($fell(error_output_pin_n));
    c_sleep: cover property (sleep_active [*3]);
endmodule : fsc_fault_status_control_regs_chk

// ===== sim/fsc_host_model.sv
// host side serial master for the register link
`timescale 1ns/100ps
module fsc_host_model (
    // serial link toward the device
    output logic      link_sclk,
    output logic      link_cs_n,
    output logic      link_sdi,
    input  wire logic link_sdo
);
    localparam int HALF = 3; // 6 ns link clock, only inside frames
    initial begin
        link_sclk = 1'b0;
        link_cs_n = 1'b1;
        link_sdi  = 1'b0;
    end
    // one frame msb first; n other than 16 gives a frame to be dropped
    task automatic frame(input logic [15:0] w, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        link_cs_n = 1'b0;
        #(HALF);
        for (int i = 0; i < n; i++) begin
            link_sclk = 1'b1;
            link_sdi = (i < 16) ? w[15 - i] : 1'b0;
            #(HALF) rx = {rx[14:0], link_sdo};
            link_sclk = 1'b0;
            #(HALF);
        end
        link_cs_n = 1'b1;
        // released line shows no stale bit
        link_sdi = ~link_sdi;
    endtask : frame
endmodule : fsc_host_model

// ===== sim/fsc_fault_status_control_regs_tb.sv
// self-checking bench for the fault status and control register bank
`timescale 1ns/100ps
module fsc_fault_status_control_regs_tb;
    // ****************************************
    // signals
    // ****************************************
    logic                    ref_clk;
    logic                    rstn;
    logic                    clk_en;
    logic                    sleep_active;
    logic                    shutdown_active;
    logic                    enable_pin;
    logic                    link_sclk;
    logic                    link_cs_n;
    logic                    link_sdi;
    logic                    link_sdo;
    logic                    error_output_pin_n;
    fsc_pkg::fsc_event_t     fault_events;
    fsc_pkg::fsc_drive_cfg_t drive_cfg;
    int                      error_cnt;
    int                      n_tests;
    logic [15:0]             rx;
    int                      dts [4] = '{10, 15, 25, 45};

    fsc_fault_status_control_regs uut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .link_sclk(link_sclk),
        .link_cs_n(link_cs_n), .link_sdi(link_sdi), .link_sdo(link_sdo), .sleep_active(sleep_active),
        .shutdown_active(shutdown_active), .enable_pin(enable_pin), .fault_events(fault_events),
        .drive_cfg(drive_cfg), .error_output_pin_n(error_output_pin_n));
    fsc_host_model host (.link_sclk(link_sclk), .link_cs_n(link_cs_n), .link_sdi(link_sdi), .link_sdo(link_sdo));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    // frame plus a deselect gap of 42 reference cycles, about 420 ns
    task automatic xfer(input logic rw, input logic [2:0] a, input logic [11:0] d, input int n);
        host.frame({rw, a, d}, n, rx);
        tick(42);
    endtask : xfer
    task automatic wr(input logic [2:0] a, input logic [11:0] d);
        xfer(1'b0, a, d, 16);
    endtask : wr
    // head bits must shift out as zero
    task automatic rd_chk(input logic [2:0] a, input logic [11:0] exp);
        xfer(1'b1, a, 12'h000, 16);
        check(rx, {4'h0, exp});
    endtask : rd_chk
    task automatic pin_chk(input logic exp);
        check({15'h0, error_output_pin_n}, {15'h0, exp});
    endtask : pin_chk
    function automatic logic [11:0] exp_p(input fsc_pkg::fsc_event_t e, input logic live);
        exp_p = {1'b1, e.supply_undervoltage_flag, 1'b0, e.pump_low_flag, |e.fet_oc, |e.shunt_oc,
                 e.thermal_warning_flag & live, e.thermal_shutdown_flag, 1'b0, e.converter_overcurrent_flag,
                 e.converter_undervoltage_flag, e.converter_overvoltage_flag};
    endfunction : exp_p

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults();
        rd_chk(3'h2, 12'h3a4);
        rd_chk(3'h0, 12'h000);
        rd_chk(3'h1, 12'h000);
        check(16'(drive_cfg), 16'h001e);
        $display("t_defaults done");
    endtask : t_defaults
    task automatic t_fields();
        logic [1:0]  c;
        logic [11:0] w;
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            w = {1'b0, 3'b011, 1'b1, c[0], 1'b1, c[1], c, c[0], c[1]};
            wr(3'h2, w);
            rd_chk(3'h2, w);
            check(16'(drive_cfg), 16'({c[0], c[1], c[1], c[0], 6'(dts[i]), 1'b0}));
        end
        $display("t_fields done");
    endtask : t_fields
    // every detector alone: set, latch after removal (the warning bit stays live), clear by write
    task automatic t_flags();
        fsc_pkg::fsc_event_t e;
        for (int i = 0; i < $bits(e); i++) begin
            e = fsc_pkg::fsc_event_t'(16'h0001 << i);
            fault_events = e;
            tick(6);
            rd_chk(3'h0, exp_p(e, 1'b1));
            rd_chk(3'h1, {e.shunt_oc, e.fet_oc, 3'h0});
            pin_chk(1'b0);
            fault_events = '0;
            tick(6);
            rd_chk(3'h0, exp_p(e, 1'b0));
            wr(3'h2, 12'hba4);
            rd_chk(3'h0, 12'h000);
            rd_chk(3'h1, 12'h000);
            rd_chk(3'h2, 12'h3a4);
            pin_chk(1'b1);
        end
        $display("t_flags done");
    endtask : t_flags
    task automatic t_enable();
        // frozen domain must not let the detector reach the flags
        clk_en = 1'b0;
        fault_events.supply_undervoltage_flag = 1'b1;
        tick(6);
        pin_chk(1'b1);
        clk_en = 1'b1;
        tick(6);
        pin_chk(1'b0);
        fault_events = '0;
        enable_pin = 1'b0;
        tick(5);
        enable_pin = 1'b1;
        tick(6);
        rd_chk(3'h0, 12'h000);
        pin_chk(1'b1);
        $display("t_enable done");
    endtask : t_enable
    task automatic t_report();
        wr(3'h2, 12'h384);
        fault_events.thermal_warning_flag = 1'b1;
        tick(6);
        pin_chk(1'b1);
        rd_chk(3'h0, 12'h020);
        fault_events = '0;
        tick(6);
        rd_chk(3'h0, 12'h000);
        $display("t_report done");
    endtask : t_report
    task automatic t_pump();
        wr(3'h2, 12'h324);
        fault_events.pump_low_flag = 1'b1;
        tick(6);
        fault_events = '0;
        check({15'h0, drive_cfg.pump_protect_trip}, 16'h0000);
        pin_chk(1'b0);
        wr(3'h2, 12'h3a4);
        check({15'h0, drive_cfg.pump_protect_trip}, 16'h0001);
        wr(3'h2, 12'hba4);
        check({15'h0, drive_cfg.pump_protect_trip}, 16'h0000);
        $display("t_pump done");
    endtask : t_pump
    task automatic t_lock();
        wr(3'h2, 12'h6a4);
        wr(3'h2, 12'h6b5);
        rd_chk(3'h2, 12'h6a4);
        wr(3'h2, 12'h1a4);
        rd_chk(3'h2, 12'h6a4);
        wr(3'h2, 12'h3a4);
        wr(3'h2, 12'h3b5);
        rd_chk(3'h2, 12'h3b5);
        $display("t_lock done");
    endtask : t_lock
    task automatic t_refuse();
        xfer(1'b0, 3'h2, 12'h3a4, 15);
        xfer(1'b0, 3'h2, 12'h3a4, 17);
        xfer(1'b0, 3'h6, 12'h3a4, 16);
        xfer(1'b0, 3'h7, 12'h3a4, 16);
        wr(3'h0, 12'hfff);
        wr(3'h1, 12'hfff);
        rd_chk(3'h2, 12'h3b5);
        rd_chk(3'h0, 12'h000);
        rd_chk(3'h1, 12'h000);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic t_sleep();
        for (int i = 0; i < 2; i++) begin
            wr(3'h2, 12'h3b5);
            sleep_active = (i == 0);
            shutdown_active = (i == 1);
            tick(4);
            sleep_active = 1'b0;
            shutdown_active = 1'b0;
            tick(2);
            rd_chk(3'h2, 12'h3a4);
        end
        $display("t_sleep done");
    endtask : t_sleep

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // main sequence
    initial begin
        rstn = 1'b0;
        clk_en = 1'b1;
        sleep_active = 1'b0;
        shutdown_active = 1'b0;
        enable_pin = 1'b1;
        fault_events = '0;
        error_cnt = 0;
        n_tests = 0;
        repeat (12) @(posedge ref_clk);
        #1 rstn = 1'b1;
        tick(4);
        t_defaults();
        t_fields();
        t_flags();
        t_enable();
        t_report();
        t_pump();
        t_lock();
        t_refuse();
        t_sleep();
        close_out();
    end
    // watchdog so a hang still reaches the verdict
    initial begin
        repeat (60000) @(posedge ref_clk);
        error_cnt++;
        close_out();
    end
endmodule : fsc_fault_status_control_regs_tb

bind fsc_fault_status_control_regs fsc_fault_status_control_regs_chk chk (.ref_clk(ref_clk), .rstn(rstn),
    .link_cs_n(link_cs_n), .link_sdo(link_sdo), .sleep_active(sleep_active), .shutdown_active(shutdown_active),
    .fault_events(fault_events), .drive_cfg(drive_cfg), .error_output_pin_n(error_output_pin_n));
